// [core/sse_defs.svh]
// Register offsets, field positions, encodings and reset values of the sleep and subtract unit
`ifndef SSE_DEFS_SVH
`define SSE_DEFS_SVH

// ***************************************************************
// Bus geometry and offsets
// ***************************************************************
`define SSE_ADDR_W    9
`define SSE_DATA_W    16
`define SSE_A_ACC     9'h000
`define SSE_A_STATUS  9'h001
`define SSE_A_ISSUE   9'h002
`define SSE_A_CTRL    9'h003
`define SSE_A_WDT     9'h004
`define SSE_A_PRE     9'h005
`define SSE_FILE_BIT  8

// ***************************************************************
// Field positions
// ***************************************************************
`define SSE_ST_C      0
`define SSE_ST_DC     1
`define SSE_ST_Z      2
`define SSE_ST_PD     3
`define SSE_ST_TO     4
`define SSE_CT_BUSY   0
`define SSE_CT_SLEEP  1
`define SSE_CT_WAKE   0

// ***************************************************************
// Encodings and reset values
// ***************************************************************
`define SSE_OP_SLEEP  14'h0063
`define SSE_OP_LITERAL_MINUS_ACC_OP  5'h1e
`define SSE_OP_REG_MINUS_ACC_OP  6'h02
`define SSE_RST_ACC   8'h00
`define SSE_RST_TO    1'b1
`define SSE_RST_PD    1'b1

`endif

// [core/sse_exec.sv]
// Four-phase executor for the power-down and the two subtract instructions
`timescale 1ns/1ns
`include "sse_defs.svh"

module sse_exec
   import sse_pkg::*;
#(
   parameter int WDT_W      = 8,
   parameter int PRE_W      = 8,
   parameter int FILE_DEPTH = 128
) (
   input  wire logic                    sys_clk_in,
   input  wire logic                    rst_in,
   input  wire logic [`SSE_ADDR_W-1:0]  addr_in,
   input  wire logic [`SSE_DATA_W-1:0]  wr_data_in,
   input  wire logic                    wr_en_in,
   input  wire logic                    rd_en_in,
   output logic      [`SSE_DATA_W-1:0]  rd_data_out,
   output logic                         busy_out,
   output logic                         osc_run_out,
   output logic                         fourth_phase_out
);

   localparam int IW = (FILE_DEPTH > 1) ? $clog2(FILE_DEPTH) : 1;
   localparam logic [7:0] DEPTH8 = 8'(FILE_DEPTH);

   // ***************************************************************
   // Parameter checks
   // ***************************************************************
   if (FILE_DEPTH < 2 || FILE_DEPTH > 128 || (1 << IW) != FILE_DEPTH) begin : g_bad_depth
      $error("FILE_DEPTH must be a power of two from 2 to 128");
   end
   if (WDT_W < 1 || WDT_W > 16 || PRE_W < 1 || PRE_W > 16) begin : g_bad_wdt
      $error("WDT_W and PRE_W must lie between 1 and 16");
   end

   // ***************************************************************
   // Decode functions
   // ***************************************************************
   function automatic sse_opclass_t op_class(input logic [13:0] op);
      if (op == `SSE_OP_SLEEP) begin
         return OPC_SLEEP;
      end else if (op[13:9] == `SSE_OP_LITERAL_MINUS_ACC_OP) begin
         return OPC_LITERAL_MINUS_ACC_OP;
      end else if (op[13:8] == `SSE_OP_REG_MINUS_ACC_OP) begin
         return OPC_REG_MINUS_ACC_OP;
      end else begin
         return OPC_NONE;
      end
   endfunction

   function automatic logic is_file(input logic [`SSE_ADDR_W-1:0] a);
      return a[`SSE_FILE_BIT] && (a[7:0] < DEPTH8);
   endfunction

   // ***************************************************************
   // State
   // ***************************************************************
   sse_phase_t        phase_ff;
   sse_phase_t        nxt_phase;
   logic [13:0]       op_ff;
   logic [7:0]        acc_ff;
   logic [7:0]        opnd_ff;
   logic [7:0]        res_ff;
   logic              c_ff;
   logic              dc_ff;
   logic              z_ff;
   logic              c_t_ff;
   logic              dc_t_ff;
   logic              z_t_ff;
   logic              to_ff;
   logic              pd_ff;
   logic              asleep_ff;
   logic [WDT_W-1:0]  wdt_cnt_ff;
   logic [PRE_W-1:0]  pre_ff;
   logic [7:0]        file_ff [FILE_DEPTH];
   logic [`SSE_DATA_W-1:0] rd_data_ff;
   logic              busy_ff;
   logic              osc_run_ff;
   logic              q4_ff;

   // ***************************************************************
   // Decode and selection
   // ***************************************************************
   wire sse_opclass_t cls       = op_class(op_ff);
   wire               idle_now  = (phase_ff == PH_IDLE);
   wire               in_q4     = (phase_ff == PH_Q4);
   wire               is_sub    = (cls == OPC_LITERAL_MINUS_ACC_OP) || (cls == OPC_REG_MINUS_ACC_OP);
   wire               dest_reg  = op_ff[7];
   wire [IW-1:0]      op_idx    = op_ff[IW-1:0];
   wire [IW-1:0]      bus_idx   = addr_in[IW-1:0];

   // Software may not disturb operands while an instruction is in flight
   wire wr_ok      = wr_en_in && idle_now;
   wire wr_acc     = wr_ok && (addr_in == `SSE_A_ACC);
   wire wr_status  = wr_ok && (addr_in == `SSE_A_STATUS);
   wire wr_file    = wr_ok && is_file(addr_in);
   wire issue      = wr_ok && !asleep_ff && (addr_in == `SSE_A_ISSUE);
   wire wake       = wr_en_in && asleep_ff && (addr_in == `SSE_A_CTRL) &&
                     wr_data_in[`SSE_CT_WAKE];

   wire commit_sleep = in_q4 && (cls == OPC_SLEEP);
   wire commit_sub   = in_q4 && is_sub;
   wire commit_acc   = in_q4 && ((cls == OPC_LITERAL_MINUS_ACC_OP) || (cls == OPC_REG_MINUS_ACC_OP && !dest_reg));
   wire commit_file  = in_q4 && (cls == OPC_REG_MINUS_ACC_OP) && dest_reg;

   // Literal or file operand is the minuend in both forms
   wire [7:0] operand = (cls == OPC_LITERAL_MINUS_ACC_OP) ? op_ff[7:0] : file_ff[op_idx];

   // Two's-complement subtraction: carry out means no borrow
   wire [8:0] diff9 = {1'b0, opnd_ff} + {1'b0, ~acc_ff} + 9'h001;
   wire [4:0] nib5  = {1'b0, opnd_ff[3:0]} + {1'b0, ~acc_ff[3:0]} + 5'h01;

   wire [7:0] status_byte = {3'h0, to_ff, pd_ff, z_ff, dc_ff, c_ff};
   wire [7:0] ctrl_byte   = {6'h00, asleep_ff, busy_ff};

   logic [`SSE_DATA_W-1:0] rd_word;
   always_comb begin
      if (addr_in == `SSE_A_ACC) begin
         rd_word = {8'h00, acc_ff};
      end else if (addr_in == `SSE_A_STATUS) begin
         rd_word = {8'h00, status_byte};
      end else if (addr_in == `SSE_A_ISSUE) begin
         rd_word = {2'b00, op_ff};
      end else if (addr_in == `SSE_A_CTRL) begin
         rd_word = {8'h00, ctrl_byte};
      end else if (addr_in == `SSE_A_WDT) begin
         rd_word = `SSE_DATA_W'(wdt_cnt_ff);
      end else if (addr_in == `SSE_A_PRE) begin
         rd_word = `SSE_DATA_W'(pre_ff);
      end else if (is_file(addr_in)) begin
         rd_word = {8'h00, file_ff[bus_idx]};
      end else begin
         rd_word = 16'h0000;
      end
   end

   // ***************************************************************
   // Phase sequencer
   // ***************************************************************
   always_comb begin
      case (phase_ff)
         PH_IDLE: nxt_phase = issue ? PH_Q1 : PH_IDLE;
         PH_Q1:   nxt_phase = PH_Q2;
         PH_Q2:   nxt_phase = PH_Q3;
         PH_Q3:   nxt_phase = PH_Q4;
         PH_Q4:   nxt_phase = PH_IDLE;
         default: nxt_phase = PH_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         phase_ff <= PH_IDLE;
         busy_ff  <= 1'b0;
         q4_ff    <= 1'b0;
      end else begin
         phase_ff <= nxt_phase;
         busy_ff  <= (nxt_phase != PH_IDLE);
         q4_ff    <= (nxt_phase == PH_Q4);
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         op_ff <= 14'h0000;
      end else if (issue) begin
         op_ff <= wr_data_in[13:0];
      end
   end

   // ***************************************************************
   // Datapath: read in the second phase, process in the third
   // ***************************************************************
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         opnd_ff <= 8'h00;
         res_ff  <= 8'h00;
         c_t_ff  <= 1'b0;
         dc_t_ff <= 1'b0;
         z_t_ff  <= 1'b0;
      end else begin
         if (phase_ff == PH_Q2) begin
            opnd_ff <= operand;
         end
         if (phase_ff == PH_Q3) begin
            res_ff  <= diff9[7:0];
            c_t_ff  <= diff9[8];
            dc_t_ff <= nib5[4];
            z_t_ff  <= (diff9[7:0] == 8'h00);
         end
      end
   end

   // ***************************************************************
   // Accumulator and arithmetic flags
   // ***************************************************************
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         acc_ff <= `SSE_RST_ACC;
      end else if (commit_acc) begin
         acc_ff <= res_ff;
      end else if (wr_acc) begin
         acc_ff <= wr_data_in[7:0];
      end
   end

   // Only the three arithmetic flags move; expiry and powerdown stay put
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         c_ff  <= 1'b0;
         dc_ff <= 1'b0;
         z_ff  <= 1'b0;
      end else if (commit_sub) begin
         c_ff  <= c_t_ff;
         dc_ff <= dc_t_ff;
         z_ff  <= z_t_ff;
      end else if (wr_status) begin
         c_ff  <= wr_data_in[`SSE_ST_C];
         dc_ff <= wr_data_in[`SSE_ST_DC];
         z_ff  <= wr_data_in[`SSE_ST_Z];
      end
   end

   // ***************************************************************
   // Data file
   // ***************************************************************
   for (genvar i = 0; i < FILE_DEPTH; i++) begin : g_file
      wire hit_ins = commit_file && (op_idx == IW'(i));
      wire hit_bus = wr_file && (bus_idx == IW'(i));
      always_ff @(posedge sys_clk_in) begin
         if (rst_in) begin
            file_ff[i] <= 8'h00;
         end else if (hit_ins) begin
            file_ff[i] <= res_ff;
         end else if (hit_bus) begin
            file_ff[i] <= wr_data_in[7:0];
         end
      end
   end

   // ***************************************************************
   // Power-down, watchdog and oscillator
   // ***************************************************************
   // The unit keeps its own clock; stopping the oscillator is signalled outward only
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         to_ff      <= `SSE_RST_TO;
         pd_ff      <= `SSE_RST_PD;
         asleep_ff  <= 1'b0;
         osc_run_ff <= 1'b1;
      end else if (commit_sleep) begin
         to_ff      <= 1'b1;
         pd_ff      <= 1'b0;
         asleep_ff  <= 1'b1;
         osc_run_ff <= 1'b0;
      end else if (wake) begin
         asleep_ff  <= 1'b0;
         osc_run_ff <= 1'b1;
      end
   end

   // Counter stands in for the watchdog so its clearing can be observed
   always_ff @(posedge sys_clk_in) begin
      if (rst_in || commit_sleep) begin
         pre_ff     <= '0;
         wdt_cnt_ff <= '0;
      end else begin
         pre_ff <= pre_ff + PRE_W'(1);
         if (&pre_ff) begin
            wdt_cnt_ff <= wdt_cnt_ff + WDT_W'(1);
         end
      end
   end

   // ***************************************************************
   // Read port
   // ***************************************************************
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         rd_data_ff <= 16'h0000;
      end else begin
         rd_data_ff <= rd_en_in ? rd_word : 16'h0000;
      end
   end

   assign rd_data_out      = rd_data_ff;
   assign busy_out         = busy_ff;
   assign osc_run_out      = osc_run_ff;
   assign fourth_phase_out = q4_ff;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   sequence s_issue_sleep;
      issue && (wr_data_in[13:0] == `SSE_OP_SLEEP);
   endsequence

   sequence s_four_phases;
      phase_ff == PH_Q1 ##1 phase_ff == PH_Q2 ##1 phase_ff == PH_Q3 ##1 phase_ff == PH_Q4;
   endsequence

   chk_sleep_decode: assert property (phase_ff == PH_Q1 && op_ff == 14'h0063 |-> cls == OPC_SLEEP)
      else $error("power-down opcode not decoded");

   chk_wdt_cleared: assert property (commit_sleep |=> wdt_cnt_ff == '0 && pre_ff == '0)
      else $error("watchdog not cleared by power-down");

   chk_expiry_set: assert property (commit_sleep |=> to_ff && status_byte[`SSE_ST_TO])
      else $error("expiry flag not set by power-down");

   chk_powerdown_clr: assert property (commit_sleep |=> !pd_ff)
      else $error("powerdown flag not cleared");

   chk_osc_stop: assert property (commit_sleep |=> !osc_run_out && asleep_ff && !busy_out)
      else $error("oscillator still running after power-down");

   chk_sleep_phases: assert property (s_issue_sleep |=> s_four_phases ##0 fourth_phase_out ##1 !osc_run_out)
      else $error("power-down phase sequence wrong");

   chk_sleep_late: assert property (s_issue_sleep |=> osc_run_out [*4])
      else $error("oscillator stopped before fourth phase");

   chk_literal_xbit: assert property (phase_ff == PH_Q1 && op_ff[13:9] == 5'h1e |-> cls == OPC_LITERAL_MINUS_ACC_OP)
      else $error("literal subtract not decoded for both x values");

   chk_literal_result: assert property (
      in_q4 && cls == OPC_LITERAL_MINUS_ACC_OP |=> acc_ff == 8'($past(op_ff[7:0]) - $past(acc_ff)))
      else $error("literal subtract result wrong");

   chk_literal_cycle: assert property (issue && op_class(wr_data_in[13:0]) == OPC_LITERAL_MINUS_ACC_OP |-> ##4 commit_acc)
      else $error("literal subtract not written in fourth phase");

   chk_other_flags: assert property (commit_sub |=> to_ff == $past(to_ff) && pd_ff == $past(pd_ff))
      else $error("subtract disturbed other status bits");

   chk_carry_flag: assert property (commit_sub |=> c_ff == ($past(opnd_ff) >= $past(acc_ff)))
      else $error("carry flag does not match borrow");

   chk_zero_flag: assert property (commit_sub |=> z_ff == ($past(opnd_ff) == $past(acc_ff)))
      else $error("zero flag wrong");

   chk_borrow_wrap: assert property (commit_sub && opnd_ff == 8'h02 && acc_ff == 8'h03 |=> !c_ff && res_ff == 8'hff)
      else $error("borrow case does not wrap");

   chk_reg_dest: assert property (commit_file |=> acc_ff == $past(acc_ff) && file_ff[$past(op_idx)] == $past(res_ff))
      else $error("register subtract destination wrong");

   chk_half_carry: assert property (commit_sub |=> dc_ff == ($past(opnd_ff[3:0]) >= $past(acc_ff[3:0])))
      else $error("nibble carry flag wrong");

endmodule // sse_exec

// [core/sse_pkg.sv]
// Types shared by the sleep and subtract unit
package sse_pkg;

   typedef enum logic [2:0] {
      PH_IDLE,
      PH_Q1,
      PH_Q2,
      PH_Q3,
      PH_Q4
   } sse_phase_t;

   typedef enum logic [1:0] {
      OPC_NONE,
      OPC_SLEEP,
      OPC_LITERAL_MINUS_ACC_OP,
      OPC_REG_MINUS_ACC_OP
   } sse_opclass_t;

endpackage

// [testbench/test_sse_exec.sv]
// Self-checking testbench for the power-down and subtract executor
`timescale 1ns/1ns
`include "sse_defs.svh"

module test_sse_exec;
   import sse_pkg::*;

   logic        sys_clk_in;
   logic        rst_in;
   logic [8:0]  addr_in;
   logic [15:0] wr_data_in;
   logic        wr_en_in;
   logic        rd_en_in;
   logic [15:0] rd_data_out;
   logic        busy_out;
   logic        osc_run_out;
   logic        fourth_phase_out;
   int          n_errors;
   int          num_checks;
   logic        pd_m;
   logic        to_m;

   sse_exec dut_u (
      .sys_clk_in       (sys_clk_in),
      .rst_in           (rst_in),
      .addr_in          (addr_in),
      .wr_data_in       (wr_data_in),
      .wr_en_in         (wr_en_in),
      .rd_en_in         (rd_en_in),
      .rd_data_out      (rd_data_out),
      .busy_out         (busy_out),
      .osc_run_out      (osc_run_out),
      .fourth_phase_out (fourth_phase_out)
   );

   // ***************************************************************
   // Clock, verdict and bus tasks
   // ***************************************************************
   initial sys_clk_in = 1'b0;
   always #4 sys_clk_in = ~sys_clk_in;

   task automatic final_report();
      if (n_errors == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Ends at the edge that takes the strobe
   task automatic wr(input logic [8:0] a, input logic [15:0] d);
      @(posedge sys_clk_in);
      addr_in    <= a;
      wr_data_in <= d;
      wr_en_in   <= 1'b1;
      @(posedge sys_clk_in);
      wr_en_in   <= 1'b0;
   endtask

   task automatic rd(input logic [8:0] a, output logic [15:0] v);
      @(posedge sys_clk_in);
      addr_in  <= a;
      rd_en_in <= 1'b1;
      @(posedge sys_clk_in);
      rd_en_in <= 1'b0;
      #1 v = rd_data_out;
   endtask

   task automatic exec(input logic [13:0] op);
      wr(`SSE_A_ISSUE, {2'b00, op});
      #1 check("busy_first", {15'h0, busy_out}, 16'h0001);
      repeat (3) @(posedge sys_clk_in);
      #1 check("fourth_phase", {15'h0, fourth_phase_out}, 16'h0001);
      @(posedge sys_clk_in);
      #1 check("busy_done", {15'h0, busy_out}, 16'h0000);
   endtask

   // ***************************************************************
   // Subtract model: minuend m, accumulator w
   // ***************************************************************
   task automatic run_sub(input bit reg_op, input logic d, input logic [6:0] f,
                          input logic [7:0] m, input logic [7:0] w, input logic x);
      logic [15:0] v;
      logic [7:0]  diff;
      logic        c;
      logic        dc;
      logic        z;
      diff = m - w;
      c    = (m >= w);
      dc   = (m[3:0] >= w[3:0]);
      z    = (diff == 8'h00);
      // Stale flags first, so a flag that never updates is caught
      wr(`SSE_A_STATUS, {13'h0, ~z, ~dc, ~c});
      wr(`SSE_A_ACC, {8'h00, w});
      if (reg_op) begin
         wr(9'h100 + {2'b00, f}, {8'h00, m});
         exec({6'b00_0010, d, f});
      end else begin
         exec({5'b11_110, x, m});
      end
      rd(`SSE_A_ACC, v);
      check("acc", v, {8'h00, (reg_op && d) ? w : diff});
      if (reg_op) begin
         rd(9'h100 + {2'b00, f}, v);
         check("file", v, {8'h00, d ? diff : m});
      end
      rd(`SSE_A_STATUS, v);
      check("status", v, {11'h0, to_m, pd_m, z, dc, c});
   endtask

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   logic [7:0]  dk [8] = '{8'h02, 8'h02, 8'h02, 8'h00, 8'hff, 8'h00, 8'h10, 8'h80};
   logic [7:0]  dw [8] = '{8'h01, 8'h02, 8'h03, 8'h00, 8'h00, 8'hff, 8'h01, 8'h7f};

   initial begin
      logic [15:0] v;
      rst_in     = 1'b1;
      addr_in    = '0;
      wr_data_in = '0;
      wr_en_in   = 1'b0;
      rd_en_in   = 1'b0;
      n_errors   = 0;
      num_checks = 0;
      pd_m       = 1'b1;
      to_m       = 1'b1;
      void'($urandom(32'he3dd7e1e));
      repeat (16) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      rd(`SSE_A_STATUS, v);
      check("status_reset", v, 16'h0018);
      check("osc_reset", {15'h0, osc_run_out}, 16'h0001);
      rd(9'h006, v);
      check("unmapped_rd", v, 16'h0000);
      wr(9'h006, 16'hffff);
      rd(9'h006, v);
      check("unmapped_wr", v, 16'h0000);
      wr(`SSE_A_STATUS, 16'hffff);
      rd(`SSE_A_STATUS, v);
      check("status_wr", v, 16'h001f);
      // Directed boundaries, both x values and both destinations
      for (int i = 0; i < 8; i++) begin
         run_sub(1'b0, 1'b0, 7'h00, dk[i], dw[i], i[0]);
         run_sub(1'b1, i[0], i[0] ? 7'h7f : 7'h00, dk[i], dw[i], 1'b0);
      end
      for (int i = 0; i < 40; i++) begin
         run_sub(1'($urandom), 1'($urandom), 7'($urandom), 8'($urandom), 8'($urandom), 1'($urandom));
      end
      // Power-down after the watchdog has had time to advance
      rd(`SSE_A_WDT, v);
      check("wdt_running", {15'h0, v != 16'h0000}, 16'h0001);
      exec(14'h0063);
      check("osc_stop", {15'h0, osc_run_out}, 16'h0000);
      pd_m = 1'b0;
      to_m = 1'b1;
      rd(`SSE_A_STATUS, v);
      check("status_sleep", {11'h0, v[4:3], 3'b000}, {11'h0, to_m, pd_m, 3'b000});
      rd(`SSE_A_WDT, v);
      check("wdt_cleared", v, 16'h0000);
      rd(`SSE_A_PRE, v);
      check("pre_cleared", {15'h0, v < 16'h0008}, 16'h0001);
      rd(`SSE_A_CTRL, v);
      check("asleep", v, 16'h0002);
      // An issue while asleep must not run
      wr(`SSE_A_ACC, 16'h0005);
      wr(`SSE_A_ISSUE, 16'h3c09);
      #1 check("busy_asleep", {15'h0, busy_out}, 16'h0000);
      rd(`SSE_A_ACC, v);
      check("acc_asleep", v, 16'h0005);
      wr(`SSE_A_CTRL, 16'h0001);
      #1 check("osc_wake", {15'h0, osc_run_out}, 16'h0001);
      run_sub(1'b0, 1'b0, 7'h00, 8'h09, 8'h05, 1'b1);
      final_report();
   end

   initial begin
      repeat (20000) @(posedge sys_clk_in);
      n_errors++;
      final_report();
   end

endmodule // test_sse_exec
